// [pwc_chan.sv]
`timescale 1ns/1ps
module pwc_chan
   import pwc_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_wrap,
   input  wire logic [9:0] i_tbase,
   input  wire logic [7:0] i_period,
   input  wire logic       i_enable,
   input  wire logic [9:0] i_duty,
   output logic            o_wave
);
   logic [9:0]  buf_ff;
   logic        wave_ff;
   logic [10:0] period_top;
   logic        full_duty;
   logic        hit;

   assign period_top = {1'b0, i_period, 2'h3} + 11'h001;
   assign full_duty  = ({1'b0, buf_ff} >= period_top);
   assign hit        = (i_tbase == buf_ff) & ~full_duty;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         buf_ff  <= 10'h000;
         wave_ff <= 1'b0;
      end else begin
         if (i_wrap) begin
            buf_ff <= i_duty;
         end
         if (!i_enable) begin
            wave_ff <= 1'b0;
         end else if (i_wrap) begin
            // zero duty stays inactive for the whole period
            wave_ff <= (i_duty != 10'h000);
         end else if (hit) begin
            wave_ff <= 1'b0;
         end
      end
   end

   assign o_wave = wave_ff;
endmodule

// [pwc_checker.sv]
`timescale 1ns/1ps
module pwc_checker
   import pwc_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_b,
   input  wire logic [AW-1:0]     i_addr,
   input  wire logic [DW-1:0]     i_wr_data,
   input  wire logic              i_wr_stb,
   input  wire logic              i_rd_stb,
   input  wire logic [DW-1:0]     o_rd_data,
   input  wire logic [NUM_CH-1:0] o_pin,
   input  wire logic [NUM_CH-1:0] o_pin_oe,
   input  wire logic [NUM_CH-1:0] o_wave,
   input  wire logic              o_period_match
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);
   wire ch_rd   = i_rd_stb && (i_addr < CH_AREA_END);
   wire dl_rd   = ch_rd && (i_addr[1:0] == OFF_DUTY_LO);
   wire ct_rd   = ch_rd && (i_addr[1:0] == OFF_CTRL);
   wire dir_wr  = i_wr_stb && (i_addr == ADDR_PINDIR);
   wire stop_wr = i_wr_stb && (i_addr == ADDR_TCTRL) && !i_wr_data[BIT_RUN];
   sequence s_match;
      o_period_match;
   endsequence
   // shortest period is four clocks
   sequence s_quiet;
      !o_period_match [*3];
   endsequence
   // a wrap taken on the stop edge still shows its pulse two edges later
   sequence s_stopped;
      !o_period_match [*8];
   endsequence
   chk_match_gap: assert property (s_match |=> s_quiet)
      else $error("match pulses closer than four clocks");
   chk_rst_pins: assert property (
      $rose(i_rst_b) |-> o_pin_oe == '0)
      else $error("pin driver on after reset");
   chk_dir_write: assert property ($changed(o_pin_oe) |->
      $past(dir_wr) || $past(dir_wr, 2))
      else $error("pin enable moved without a direction write");
   chk_rd_idle: assert property (
      !$past(i_rd_stb) |-> o_rd_data == '0)
      else $error("read data outside the read slot");
   chk_duty_low: assert property (
      dl_rd |=> o_rd_data[5:0] == 6'h00)
      else $error("duty low spare bits not zero");
   chk_ctrl_low: assert property (
      ct_rd |=> o_rd_data[3:0] == 4'h0)
      else $error("control spare bits not zero");
   chk_pin_wave: assert property ((o_pin & ~o_wave) == '0)
      else $error("pin high while waveform low");
   chk_stop_quiet: assert property (stop_wr |=> ##2 s_stopped)
      else $error("match pulse after timer stop");
   cov_match: cover property (s_match ##1 s_quiet);
endmodule

bind pwc_top pwc_checker pwc_checker_inst (
   .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
   .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
   .o_rd_data(o_rd_data), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
   .o_wave(o_wave), .o_period_match(o_period_match)
);

// [pwc_pkg.sv]
package pwc_pkg;
   localparam int          NUM_CH       = 4;
   localparam int          AW           = 8;
   localparam int          DW           = 8;
   localparam int          CLK_PERIOD_NS = 8;

   // per channel registers at CH_STRIDE * channel + local offset
   localparam logic [7:0]  CH_STRIDE    = 8'h04;
   localparam logic [1:0]  OFF_CTRL     = 2'h0;
   localparam logic [1:0]  OFF_DUTY_HI  = 2'h1;
   localparam logic [1:0]  OFF_DUTY_LO  = 2'h2;
   localparam logic [7:0]  CH_AREA_END  = 8'h10;
   localparam logic [7:0]  ADDR_PERIOD  = 8'h10;
   localparam logic [7:0]  ADDR_TCTRL   = 8'h11;
   localparam logic [7:0]  ADDR_TCOUNT  = 8'h12;
   localparam logic [7:0]  ADDR_FLAGS   = 8'h13;
   localparam logic [7:0]  ADDR_PINDIR  = 8'h14;

   localparam int          BIT_EN       = 7;
   localparam int          BIT_OE       = 6;
   localparam int          BIT_OUT      = 5;
   localparam int          BIT_POL      = 4;
   localparam int          BIT_RUN      = 2;
   localparam int          BIT_MATCH    = 0;

   localparam logic [7:0]  RST_CTRL     = 8'h00;
   localparam logic [7:0]  RST_DUTY     = 8'h00;
   localparam logic [7:0]  RST_PERIOD   = 8'hff;
   localparam logic [7:0]  RST_TCTRL    = 8'h00;
   localparam logic [3:0]  RST_PINDIR   = 4'hf;

   // prescale terminal counts for 1:1, 1:4, 1:16, 1:64
   localparam logic [5:0]  PS_LIM_1     = 6'h00;
   localparam logic [5:0]  PS_LIM_4     = 6'h03;
   localparam logic [5:0]  PS_LIM_16    = 6'h0f;
   localparam logic [5:0]  PS_LIM_64    = 6'h3f;
endpackage

// [pwc_sink.sv]
`timescale 1ns/1ps
module pwc_sink (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   input  wire logic [3:0]  i_wave,
   input  wire logic [3:0]  i_pin,
   input  wire logic [3:0]  i_pin_oe,
   input  wire logic        i_match,
   output logic [3:0][10:0] o_hi,
   output logic [10:0]      o_len,
   output logic [3:0]       o_level
);
   logic [3:0][10:0] acc_ff;
   logic [10:0]      len_ff;
   // undriven pin is pulled down, as for an internal-only channel
   assign o_level = i_pin & i_pin_oe;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         acc_ff <= '0;
         len_ff <= '0;
         o_hi   <= '0;
         o_len  <= '0;
      end else if (i_match) begin
         o_hi   <= acc_ff;
         o_len  <= len_ff;
         len_ff <= 11'h001;
         for (int k = 0; k < 4; k++) acc_ff[k] <= {10'h000, i_wave[k]};
      end else begin
         len_ff <= len_ff + 11'h001;
         for (int k = 0; k < 4; k++) acc_ff[k] <= acc_ff[k] + 11'(i_wave[k]);
      end
   end
endmodule

// [pwc_tbase.sv]
`timescale 1ns/1ps
module pwc_tbase
   import pwc_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_run,
   input  wire logic [1:0] i_ps_sel,
   input  wire logic [7:0] i_period,
   output logic      [9:0] o_tbase,
   output logic            o_wrap
);
   logic [5:0] pre_ff;
   logic [9:0] tbase_ff;
   logic       wrap_ff;
   logic [5:0] ps_lim;
   logic       step;
   logic       at_end;

   assign ps_lim = (i_ps_sel == 2'h0) ? PS_LIM_1  :
                   (i_ps_sel == 2'h1) ? PS_LIM_4  :
                   (i_ps_sel == 2'h2) ? PS_LIM_16 : PS_LIM_64;
   // every step is a whole number of system clocks
   assign step   = i_run & (pre_ff >= ps_lim);
   assign at_end = (tbase_ff[9:2] == i_period) & (tbase_ff[1:0] == 2'h3);

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pre_ff   <= 6'h00;
         tbase_ff <= 10'h000;
         wrap_ff  <= 1'b0;
      end else begin
         wrap_ff <= step & at_end;
         if (step) begin
            pre_ff   <= 6'h00;
            tbase_ff <= at_end ? 10'h000 : tbase_ff + 10'h001;
         end else if (i_run) begin
            pre_ff <= pre_ff + 6'h01;
         end
      end
   end

   assign o_tbase = tbase_ff;
   assign o_wrap  = wrap_ff;
endmodule

// [pwc_top.sv]
`timescale 1ns/1ps
module pwc_top
   import pwc_pkg::*;
(
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst_b,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [DW-1:0] i_wr_data,
   input  wire logic          i_wr_stb,
   input  wire logic          i_rd_stb,
   output logic      [DW-1:0] o_rd_data,
   output logic [NUM_CH-1:0]  o_pin,
   output logic [NUM_CH-1:0]  o_pin_oe,
   output logic [NUM_CH-1:0]  o_wave,
   output logic               o_period_match
);
   // shared timer state
   logic [7:0]        period_ff;
   logic [7:0]        tctrl_ff;
   logic              flag_ff;
   logic [3:0]        pindir_ff;
   logic [9:0]        tbase;
   logic              wrap;

   // per channel configuration
   logic [7:0]        ctrl_ff   [NUM_CH];
   logic [7:0]        dhi_ff    [NUM_CH];
   logic [1:0]        dlo_ff    [NUM_CH];
   logic [NUM_CH-1:0] raw_wave;
   logic [NUM_CH-1:0] nxt_wave;
   logic [NUM_CH-1:0] nxt_pin;
   logic [NUM_CH-1:0] nxt_pin_oe;
   logic [NUM_CH-1:0] wave_ff;
   logic [NUM_CH-1:0] pin_ff;
   logic [NUM_CH-1:0] pin_oe_ff;
   logic [DW-1:0]     rd_data_ff;
   logic              match_ff;

   // address decode
   logic              in_ch_area;
   logic [1:0]        ch_sel;
   logic [1:0]        ch_off;
   logic              wr_period;
   logic              wr_tctrl;
   logic              wr_flags;
   logic              wr_pindir;
   logic [NUM_CH-1:0] wr_ctrl;
   logic [NUM_CH-1:0] wr_dhi;
   logic [NUM_CH-1:0] wr_dlo;
   logic              flag_clr;
   logic [DW-1:0]     ch_rd;
   logic [DW-1:0]     rd_mux;
   logic [DW-1:0]     state_byte [NUM_CH];

   assign in_ch_area = (i_addr < CH_AREA_END);
   assign ch_sel     = i_addr[3:2];
   assign ch_off     = i_addr[1:0];
   assign wr_period  = i_wr_stb & (i_addr == ADDR_PERIOD);
   assign wr_tctrl   = i_wr_stb & (i_addr == ADDR_TCTRL);
   assign wr_flags   = i_wr_stb & (i_addr == ADDR_FLAGS);
   assign wr_pindir  = i_wr_stb & (i_addr == ADDR_PINDIR);
   assign flag_clr   = wr_flags & i_wr_data[BIT_MATCH];

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_dec
         logic hit_ch;
         assign hit_ch     = i_wr_stb & in_ch_area & (ch_sel == 2'(g));
         assign wr_ctrl[g] = hit_ch & (ch_off == OFF_CTRL);
         assign wr_dhi[g]  = hit_ch & (ch_off == OFF_DUTY_HI);
         assign wr_dlo[g]  = hit_ch & (ch_off == OFF_DUTY_LO);
      end
   endgenerate

   // shared timer and period
   pwc_tbase u_tbase (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_run     (tctrl_ff[BIT_RUN]),
      .i_ps_sel  (tctrl_ff[1:0]),
      .i_period  (period_ff),
      .o_tbase   (tbase),
      .o_wrap    (wrap)
   );

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         period_ff <= RST_PERIOD;
         tctrl_ff  <= RST_TCTRL;
         pindir_ff <= RST_PINDIR;
      end else begin
         if (wr_period) begin
            period_ff <= i_wr_data;
         end
         if (wr_tctrl) begin
            tctrl_ff <= {5'h00, i_wr_data[2:0]};
         end
         if (wr_pindir) begin
            pindir_ff <= i_wr_data[3:0];
         end
      end
   end

   // a match in the same cycle as a clear is kept
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flag_ff <= 1'b0;
      end else if (wrap) begin
         flag_ff <= 1'b1;
      end else if (flag_clr) begin
         flag_ff <= 1'b0;
      end
   end

   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               ctrl_ff[g] <= RST_CTRL;
               dhi_ff[g]  <= RST_DUTY;
               dlo_ff[g]  <= 2'h0;
            end else begin
               if (wr_ctrl[g]) begin
                  // output state bit and low nibble are not stored
                  ctrl_ff[g] <= {i_wr_data[7:6], 1'b0,
                                 i_wr_data[4], 4'h0};
               end
               if (wr_dhi[g]) begin
                  dhi_ff[g] <= i_wr_data;
               end
               if (wr_dlo[g]) begin
                  dlo_ff[g] <= i_wr_data[7:6];
               end
            end
         end

         pwc_chan u_chan (
            .i_ref_clk (i_ref_clk),
            .i_rst_b   (i_rst_b),
            .i_wrap    (wrap),
            .i_tbase   (tbase),
            .i_period  (period_ff),
            .i_enable  (ctrl_ff[g][BIT_EN]),
            .i_duty    ({dhi_ff[g], dlo_ff[g]}),
            .o_wave    (raw_wave[g])
         );

         // polarity applies after the compare so it flips at once
         assign nxt_wave[g]   = raw_wave[g] ^
                                ctrl_ff[g][BIT_POL];
         assign nxt_pin[g]    = ctrl_ff[g][BIT_OE] &
                                nxt_wave[g];
         assign nxt_pin_oe[g] = ~pindir_ff[g];
         assign state_byte[g] = {ctrl_ff[g][7:6], wave_ff[g],
                                 ctrl_ff[g][4], 4'h0};
      end
   endgenerate

   // read data path
   always_comb begin
      case (ch_off)
         OFF_CTRL:    ch_rd = state_byte[ch_sel];
         OFF_DUTY_HI: ch_rd = dhi_ff[ch_sel];
         OFF_DUTY_LO: ch_rd = {dlo_ff[ch_sel], 6'h00};
         default:     ch_rd = 8'h00;
      endcase
   end

   always_comb begin
      if (in_ch_area) begin
         rd_mux = ch_rd;
      end else begin
         case (i_addr)
            ADDR_PERIOD: rd_mux = period_ff;
            ADDR_TCTRL:  rd_mux = tctrl_ff;
            ADDR_TCOUNT: rd_mux = tbase[9:2];
            ADDR_FLAGS:  rd_mux = {7'h00, flag_ff};
            ADDR_PINDIR: rd_mux = {4'h0, pindir_ff};
            default:     rd_mux = 8'h00;
         endcase
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_data_ff <= 8'h00;
      end else begin
         rd_data_ff <= i_rd_stb ? rd_mux : 8'h00;
      end
   end

   // outputs are registered to keep pins glitch free
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wave_ff   <= 4'h0;
         pin_ff    <= 4'h0;
         pin_oe_ff <= 4'h0;
         match_ff  <= 1'b0;
      end else begin
         wave_ff   <= nxt_wave;
         pin_ff    <= nxt_pin;
         pin_oe_ff <= nxt_pin_oe;
         match_ff  <= wrap;
      end
   end

   assign o_rd_data      = rd_data_ff;
   assign o_wave         = wave_ff;
   assign o_pin          = pin_ff;
   assign o_pin_oe       = pin_oe_ff;
   assign o_period_match = match_ff;
endmodule

// [pwc_top_tb.sv]
`timescale 1ns/1ps
module pwc_top_tb
   import pwc_pkg::*;
;
   logic             i_ref_clk, i_rst_b, i_wr_stb, i_rd_stb, o_period_match;
   logic [7:0]       i_addr, i_wr_data, o_rd_data, rdv;
   logic [3:0]       o_pin, o_pin_oe, o_wave, lvl;
   logic [3:0][10:0] hi;
   logic [10:0]      len;
   int               n_errors = 0, checks_done = 0, cyc = 0;
   logic [7:0] ra [10] = '{8'h00, 8'h01, 8'h02, 8'h0c, 8'h10, 8'h11, 8'h12,
                           8'h13, 8'h14, 8'h20};
   logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
                           8'h00, 8'h0f, 8'h00};
   logic [7:0]  dh [4] = '{8'h01, 8'h02, 8'h00, 8'h04};
   logic [7:0]  dl [4] = '{8'h00, 8'h40, 8'h00, 8'h00};
   logic [10:0] dx [4] = '{11'd4, 11'd9, 11'd0, 11'd16};
   pwc_top pwc_top_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb),
      .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .o_pin(o_pin),
      .o_pin_oe(o_pin_oe), .o_wave(o_wave), .o_period_match(o_period_match));
   pwc_sink pwc_sink_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .i_wave(o_wave), .i_pin(o_pin), .i_pin_oe(o_pin_oe),
      .i_match(o_period_match), .o_hi(hi), .o_len(len), .o_level(lvl));
   initial begin
      i_ref_clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) i_ref_clk = ~i_ref_clk;
   end
   function automatic logic [7:0] ca(input int k, input logic [1:0] o);
      return CH_STRIDE * 8'(k) + {6'h00, o};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_wr_stb  <= 1'b1;
      i_addr    <= a;
      i_wr_data <= d;
      @(posedge i_ref_clk);
      i_wr_stb  <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_ref_clk);
      i_rd_stb <= 1'b1;
      i_addr   <= a;
      @(posedge i_ref_clk);
      i_rd_stb <= 1'b0;
      #1;
      rdv = o_rd_data;
   endtask
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp11(input logic [10:0] g, input logic [10:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      cmp8(rdv, e);
   endtask
   task automatic settle;
      repeat (3) @(posedge i_ref_clk);
      #1;
   endtask
   // sink latches one edge after the pulse, hence the extra edge
   task automatic wm(input int n);
      int j;
      repeat (n) begin
         j = 0;
         do begin
            @(posedge i_ref_clk);
            #1;
            j++;
         end while (o_period_match !== 1'b1 && j < 1100);
         if (o_period_match !== 1'b1) n_errors++;
      end
      @(posedge i_ref_clk);
      #1;
   endtask
   task automatic tend(input string s);
      $display("test %s done", s);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         final_report;
      end
   end
   initial begin
      {i_rst_b, i_wr_stb, i_rd_stb, i_addr, i_wr_data, rdv} = '0;
      repeat (16) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      for (int i = 0; i < 10; i++) chk(ra[i], rv[i]);
      tend("reset");
      wr(ca(1, OFF_CTRL), 8'h2f);
      chk(ca(1, OFF_CTRL), 8'h00);
      wr(ca(1, OFF_DUTY_LO), 8'hff);
      chk(ca(1, OFF_DUTY_LO), 8'hc0);
      wr(ca(1, OFF_DUTY_HI), 8'ha5);
      chk(ca(1, OFF_DUTY_HI), 8'ha5);
      tend("fields");
      wr(ADDR_PINDIR, 8'h0f);
      for (int k = 0; k < 4; k++) wr(ca(k, OFF_CTRL), 8'h00);
      wr(ADDR_PERIOD, 8'h03);
      for (int k = 0; k < 4; k++) begin
         wr(ca(k, OFF_DUTY_HI), dh[k]);
         wr(ca(k, OFF_DUTY_LO), dl[k]);
      end
      wr(ADDR_FLAGS, 8'h01);
      chk(ADDR_FLAGS, 8'h00);
      wr(ADDR_TCTRL, 8'h00);
      wr(ADDR_TCTRL, 8'h04);
      for (int i = 0; i < 20 && rdv[BIT_MATCH] !== 1'b1; i++) begin
         rd(ADDR_FLAGS);
      end
      cmp8(rdv & 8'h01, 8'h01);
      // clear the set flag well before the next wrap can set it again
      wr(ADDR_FLAGS, 8'h01);
      chk(ADDR_FLAGS, 8'h00);
      wr(ADDR_PINDIR, 8'h00);
      for (int k = 0; k < 4; k++) wr(ca(k, OFF_CTRL), 8'hc0);
      cmp8({4'h0, o_pin_oe}, 8'h0f);
      // first enabled period starts with the wave low; judge the next one
      wm(3);
      for (int k = 0; k < 4; k++) begin
         cmp11(hi[k], dx[k]);
      end
      tend("duty");
      chk(ca(3, OFF_CTRL), 8'he0);
      cmp8({7'h00, lvl[3]}, 8'h01);
      wr(ca(3, OFF_CTRL), 8'h80);
      settle;
      cmp8({7'h00, lvl[3]}, 8'h00);
      wm(1);
      wr(ca(0, OFF_DUTY_HI), 8'h02);
      wm(1);
      cmp11(hi[0], 11'd4);
      wm(1);
      cmp11(hi[0], 11'd8);
      wr(ca(2, OFF_CTRL), 8'hd0);
      wr(ca(3, OFF_CTRL), 8'h40);
      wm(2);
      cmp11(hi[2], 11'd16);
      cmp11(hi[3], 11'd0);
      tend("modes");
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_TCTRL, 8'h04 | 8'(p));
         wm(2);
         cmp11(len, 11'd16 << (2 * p));
      end
      tend("prescale");
      wr(ADDR_TCTRL, 8'h00);
      @(posedge i_ref_clk);
      i_rst_b <= 1'b0;
      settle;
      cmp8({4'h0, o_pin_oe}, 8'h00);
      @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      chk(ca(3, OFF_CTRL), 8'h00);
      chk(ADDR_PERIOD, 8'hff);
      tend("reset2");
      final_report;
   end
endmodule
